// File: atrs_top.sv
`timescale 1ns/1ps
`include "atrs_regs.svh"
// Overview of operation
// - Select code zero starts no automatic conversion, leaving only software starts.
// - Codes 1000 to 1011 pick logic cell outputs one to four as the start source.
// - Code 1100 picks the fourth timer match and code 1101 the sixth timer match.
// - A source used as trigger still sets its own interrupt flag in its own block.
// - In left-justify format the high byte holds result bits 9 to 2.
// - In left-justify format the low byte holds result bits 1 and 0 in bits 7 and 6.
// - In right-justify format the high byte holds bits 9 and 8 low, the low byte bits 7 to 0.
// - Result contents are not cleared by reset other than power-on and brown-out.
// - Unimplemented bits, including the low four select bits, read zero and ignore writes.
// - Software can read and write the result registers; all eight high-byte bits in left-justify format, only bits 1 and 0 in right-justify.
module atrs_top import atrs_pkg::*; (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_ccp1_event,
    input wire logic i_ccp2_event,
    input wire logic i_timer_zero_overflow,
    input wire logic i_timer_one_overflow,
    input wire logic i_timer_two_match,
    input wire logic i_comparator_one_synced_output,
    input wire logic i_comparator_two_synced_output,
    input wire logic [3:0] i_logic_cell_output,
    input wire logic i_timer_four_match,
    input wire logic i_timer_six_match,
    input wire logic i_result_valid,
    input wire logic [9:0] i_conversion_result,
    output logic [7:0] o_rdata,
    output logic o_conversion_start,
    output logic o_result_justify_format,
    output logic [3:0] o_trigger_source_select,
    output logic o_irq
);
    atrs_state_s state_reg;
    atrs_state_s state_next;
    logic trig_level;
    logic trig_rise;
    logic [7:0] high_byte;
    logic [7:0] low_byte;
    logic [9:0] wr_result;
    logic [1:0] events;

    // Sources are on-chip and already on this clock, so no synchroniser.
    always_comb begin
        unique case (atrs_src_e'(state_reg.trig_sel))
            ATRS_SRC_NONE: trig_level = 1'b0;
            ATRS_SRC_CCP1: trig_level = i_ccp1_event;
            ATRS_SRC_CCP2: trig_level = i_ccp2_event;
            ATRS_SRC_TMR0: trig_level = i_timer_zero_overflow;
            ATRS_SRC_TMR1: trig_level = i_timer_one_overflow;
            ATRS_SRC_TMR2: trig_level = i_timer_two_match;
            ATRS_SRC_CMP1: trig_level = i_comparator_one_synced_output;
            ATRS_SRC_CMP2: trig_level = i_comparator_two_synced_output;
            ATRS_SRC_LC1: trig_level = i_logic_cell_output[0];
            ATRS_SRC_LC2: trig_level = i_logic_cell_output[1];
            ATRS_SRC_LC3: trig_level = i_logic_cell_output[2];
            ATRS_SRC_LC4: trig_level = i_logic_cell_output[3];
            ATRS_SRC_TMR4: trig_level = i_timer_four_match;
            ATRS_SRC_TMR6: trig_level = i_timer_six_match;
            ATRS_SRC_RSV0: trig_level = 1'b0;
            ATRS_SRC_RSV1: trig_level = 1'b0;
        endcase
    end

    // Source flags are left to their own blocks; only the level is observed here.
    assign trig_rise = trig_level & ~state_reg.trig_prev;

    always_comb begin
        if (state_reg.format_right) begin
            high_byte = {6'h00, state_reg.result[9:8]};
            low_byte = state_reg.result[7:0];
        end else begin
            high_byte = state_reg.result[9:2];
            low_byte = {state_reg.result[1:0], 6'h00};
        end
    end

    always_comb begin
        wr_result = state_reg.result;
        if (i_wr && i_addr == `ATRS_ADDR_RES_HIGH) begin
            if (state_reg.format_right) begin
                wr_result[9:8] = i_wdata[1:0];
            end else begin
                wr_result[9:2] = i_wdata;
            end
        end
        if (i_wr && i_addr == `ATRS_ADDR_RES_LOW) begin
            if (state_reg.format_right) begin
                wr_result[7:0] = i_wdata;
            end else begin
                wr_result[1:0] = i_wdata[7:6];
            end
        end
    end

    assign events = {i_result_valid, trig_rise};

    always_comb begin
        state_next = state_reg;
        state_next.trig_prev = trig_level;
        state_next.start = trig_rise;
        state_next.result = wr_result;
        if (i_result_valid) begin
            state_next.result = i_conversion_result;
        end
        if (i_wr) begin
            unique case (i_addr)
                `ATRS_ADDR_TRIG_SEL: begin
                    state_next.trig_sel = i_wdata[`ATRS_TRIG_SEL_MSB:`ATRS_TRIG_SEL_LSB];
                end
                `ATRS_ADDR_CONTROL: begin
                    state_next.format_right = i_wdata[`ATRS_CTRL_FORMAT_BIT];
                end
                `ATRS_ADDR_INT_MASK: begin
                    state_next.int_mask = i_wdata[1:0];
                end
                `ATRS_ADDR_SW_START: begin
                    state_next.start = trig_rise | i_wdata[0];
                end
                default: begin
                end
            endcase
        end
        // A new event wins over a write-one clear in the same cycle.
        if (i_wr && i_addr == `ATRS_ADDR_INT_STATUS) begin
            state_next.int_status = (state_reg.int_status & ~i_wdata[1:0]) | events;
        end else begin
            state_next.int_status = state_reg.int_status | events;
        end
        state_next.rdata = 8'h00;
        if (i_rd) begin
            unique case (i_addr)
                `ATRS_ADDR_TRIG_SEL: state_next.rdata = {state_reg.trig_sel, 4'h0};
                `ATRS_ADDR_CONTROL: state_next.rdata = {7'h00, state_reg.format_right};
                `ATRS_ADDR_RES_HIGH: state_next.rdata = high_byte;
                `ATRS_ADDR_RES_LOW: state_next.rdata = low_byte;
                `ATRS_ADDR_INT_STATUS: state_next.rdata = {6'h00, state_reg.int_status};
                `ATRS_ADDR_INT_MASK: state_next.rdata = {6'h00, state_reg.int_mask};
                default: state_next.rdata = 8'h00;
            endcase
        end
    end

    // Result is cleared only by the device-level reset, standing in for power-on.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg.trig_sel <= `ATRS_TRIG_SEL_RESET;
            state_reg.format_right <= `ATRS_CTRL_RESET;
            state_reg.result <= `ATRS_RESULT_RESET;
            state_reg.int_status <= `ATRS_INT_RESET;
            state_reg.int_mask <= `ATRS_INT_RESET;
            state_reg.trig_prev <= 1'b0;
            state_reg.rdata <= 8'h00;
            state_reg.start <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_rdata = state_reg.rdata;
    assign o_conversion_start = state_reg.start;
    assign o_result_justify_format = state_reg.format_right;
    assign o_trigger_source_select = state_reg.trig_sel;
    assign o_irq = |(state_reg.int_status & state_reg.int_mask);
endmodule

// File: atrs_regs.svh
`ifndef ATRS_REGS_SVH
`define ATRS_REGS_SVH
`define ATRS_ADDR_TRIG_SEL 8'h00
`define ATRS_ADDR_CONTROL 8'h01
`define ATRS_ADDR_RES_HIGH 8'h02
`define ATRS_ADDR_RES_LOW 8'h03
`define ATRS_ADDR_INT_STATUS 8'h04
`define ATRS_ADDR_INT_MASK 8'h05
`define ATRS_ADDR_SW_START 8'h06
`define ATRS_TRIG_SEL_MSB 7
`define ATRS_TRIG_SEL_LSB 4
`define ATRS_CTRL_FORMAT_BIT 0
`define ATRS_TRIG_SEL_RESET 4'h0
`define ATRS_CTRL_RESET 1'b0
`define ATRS_INT_STATUS_START 0
`define ATRS_INT_STATUS_DONE 1
`define ATRS_INT_RESET 2'h0
`define ATRS_RESULT_RESET 10'h000
`endif

// File: atrs_pkg.sv
package atrs_pkg;
    typedef enum logic [3:0] {
        ATRS_SRC_NONE = 4'h0,
        ATRS_SRC_CCP1 = 4'h1,
        ATRS_SRC_CCP2 = 4'h2,
        ATRS_SRC_TMR0 = 4'h3,
        ATRS_SRC_TMR1 = 4'h4,
        ATRS_SRC_TMR2 = 4'h5,
        ATRS_SRC_CMP1 = 4'h6,
        ATRS_SRC_CMP2 = 4'h7,
        ATRS_SRC_LC1 = 4'h8,
        ATRS_SRC_LC2 = 4'h9,
        ATRS_SRC_LC3 = 4'hA,
        ATRS_SRC_LC4 = 4'hB,
        ATRS_SRC_TMR4 = 4'hC,
        ATRS_SRC_TMR6 = 4'hD,
        ATRS_SRC_RSV0 = 4'hE,
        ATRS_SRC_RSV1 = 4'hF
    } atrs_src_e;

    typedef struct packed {
        logic [3:0] trig_sel;
        logic format_right;
        logic [9:0] result;
        logic [1:0] int_status;
        logic [1:0] int_mask;
        logic trig_prev;
        logic [7:0] rdata;
        logic start;
    } atrs_state_s;
endpackage

// File: atrs_monitor.sv
`timescale 1ns/1ps
module atrs_monitor (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [3:0] i_logic_cell_output,
    input wire logic i_timer_four_match,
    input wire logic i_timer_six_match,
    input wire logic i_result_valid,
    input wire logic [9:0] i_conversion_result,
    input wire logic [7:0] o_rdata,
    input wire logic o_conversion_start,
    input wire logic o_result_justify_format,
    input wire logic [3:0] o_trigger_source_select
);
    logic [5:0] late_src;
    logic [2:0] late_idx;
    logic quiet_sel;
    assign late_src = {i_timer_six_match, i_timer_four_match, i_logic_cell_output};
    assign late_idx = 3'(o_trigger_source_select - 4'h8);
    assign quiet_sel = o_trigger_source_select == 4'h0 || o_trigger_source_select > 4'hD;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    sequence cap_s(fmt);
        i_result_valid && !i_wr && o_result_justify_format == fmt;
    endsequence
    sequence rd_s(a);
        i_rd && i_addr == a;
    endsequence
    rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside read slot");
    sel_low_a: assert property ($past(i_rd && i_addr == 8'h00) |-> o_rdata[3:0] == 4'h0)
        else $error("select low bits not zero");
    trig_rise_a: assert property (o_trigger_source_select inside {[4'h8:4'hD]} &&
        $stable(o_trigger_source_select) && $rose(late_src[late_idx]) |=> o_conversion_start)
        else $error("selected rise gave no start");
    no_start_a: assert property (quiet_sel && $stable(o_trigger_source_select) &&
        !(i_wr && i_addr == 8'h06 && i_wdata[0]) |=> !o_conversion_start)
        else $error("start without selected source");
    left_high_a: assert property (cap_s(1'b0) ##2 rd_s(8'h02) |=>
        o_rdata == $past(i_conversion_result[9:2], 3)) else $error("left high byte wrong");
    left_low_a: assert property (cap_s(1'b0) ##2 rd_s(8'h03) |=>
        o_rdata == {$past(i_conversion_result[1:0], 3), 6'h00}) else $error("left low byte wrong");
    right_high_a: assert property (cap_s(1'b1) ##2 rd_s(8'h02) |=>
        o_rdata == {6'h00, $past(i_conversion_result[9:8], 3)}) else $error("right high wrong");
    right_low_a: assert property (cap_s(1'b1) ##2 rd_s(8'h03) |=>
        o_rdata == $past(i_conversion_result[7:0], 3)) else $error("right low byte wrong");
endmodule
bind atrs_top atrs_monitor i_mon (.*);

// File: atrs_src_model.sv
`timescale 1ns/1ps
module atrs_src_model (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_fire,
    input wire logic [15:0] i_pick,
    output logic [15:0] o_src
);
    logic hold_reg;
    // Each event stands two cycles, then drops, so every firing is a fresh rise.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            hold_reg <= 1'b0;
            o_src <= 16'h0000;
        end else begin
            hold_reg <= i_fire;
            if (i_fire) begin
                o_src <= i_pick;
            end else if (!hold_reg) begin
                o_src <= 16'h0000;
            end
        end
    end
endmodule

// File: tb_adc_trigger_select_and_result.sv
`timescale 1ns/1ps
module tb_adc_trigger_select_and_result;
    import atrs_pkg::*;
    logic i_clk = 1'b0, i_reset_n = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_result_valid = 1'b0;
    logic [7:0] i_addr = 8'h00, i_wdata = 8'h00;
    logic [9:0] i_conversion_result = 10'h000;
    logic i_ccp1_event, i_ccp2_event, i_timer_zero_overflow, i_timer_one_overflow;
    logic i_timer_two_match, i_comparator_one_synced_output, i_comparator_two_synced_output;
    logic i_timer_four_match, i_timer_six_match, fire = 1'b0;
    logic [3:0] i_logic_cell_output, o_trigger_source_select;
    logic [15:0] src, pick = 16'h0000;
    logic [7:0] o_rdata;
    logic o_conversion_start, o_result_justify_format, o_irq;
    int num_errors = 0, total_checks = 0, starts = 0, cycles = 0;
    assign {i_timer_six_match, i_timer_four_match, i_logic_cell_output,
        i_comparator_two_synced_output, i_comparator_one_synced_output, i_timer_two_match,
        i_timer_one_overflow, i_timer_zero_overflow, i_ccp2_event, i_ccp1_event} = src[13:1];
    atrs_top i_dut (.*);
    atrs_src_model i_src (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_fire(fire),
        .i_pick(pick), .o_src(src));
    always #20 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        starts += (o_conversion_start === 1'b1);
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            report_and_stop();
        end
    end
    task automatic chk(string n, logic [7:0] s, logic [7:0] e);
        total_checks++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rdc(string n, logic [7:0] a, logic [7:0] e);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk(n, o_rdata, e);
    endtask
    task automatic cap(logic [9:0] r);
        @(posedge i_clk);
        i_result_valid <= 1'b1;
        i_conversion_result <= r;
        @(posedge i_clk);
        i_result_valid <= 1'b0;
    endtask
    task automatic shoot(logic [15:0] m);
        @(posedge i_clk);
        fire <= 1'b1;
        pick <= m;
        @(posedge i_clk);
        fire <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask
    task automatic t_regs();
        wr(8'h00, 8'hFF);
        rdc("select", 8'h00, 8'hF0);
        chk("select out", {o_trigger_source_select, 4'h0}, 8'hF0);
        wr(8'h02, 8'hA5);
        rdc("high byte", 8'h02, 8'hA5);
        wr(8'h03, 8'hFF);
        rdc("low byte", 8'h03, 8'hC0);
        rdc("unmapped", 8'h20, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_result();
        logic [9:0] r;
        r = 10'h2B6;
        for (int f = 0; f < 2; f++) begin
            wr(8'h01, 8'(f));
            #1 chk("format out", {7'h00, o_result_justify_format}, 8'(f));
            cap(r);
            rdc("result high", 8'h02, f ? {6'h00, r[9:8]} : r[9:2]);
            rdc("result low", 8'h03, f ? r[7:0] : {r[1:0], 6'h00});
            r = ~r;
        end
        $display("test result done");
    endtask
    task automatic t_trig();
        for (int c = 0; c < 16; c++) begin
            wr(8'h00, 8'(c << 4));
            starts = 0;
            shoot(c inside {0, 14, 15} ? 16'hFFFF : ~(16'h0001 << c));
            chk("other source", 8'(starts), 8'h00);
            shoot(16'h0001 << c);
            chk("chosen source", 8'(starts), 8'(!(c inside {0, 14, 15})));
        end
        $display("test trigger done");
    endtask
    task automatic t_irq();
        wr(8'h00, 8'h00);
        starts = 0;
        wr(8'h06, 8'h01);
        @(posedge i_clk);
        #1 chk("software start", 8'(starts), 8'h01);
        wr(8'h04, 8'h03);
        wr(8'h05, 8'h01);
        cap(10'h155);
        #1 chk("irq masked", {7'h00, o_irq}, 8'h00);
        rdc("status", 8'h04, 8'h02);
        wr(8'h05, 8'h03);
        #1 chk("irq raised", {7'h00, o_irq}, 8'h01);
        wr(8'h04, 8'h02);
        #1 chk("irq cleared", {7'h00, o_irq}, 8'h00);
        $display("test irq done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        i_reset_n = 1'b0;
        repeat (4) @(posedge i_clk);
        i_reset_n <= 1'b1;
        t_regs();
        t_result();
        t_trig();
        t_irq();
        report_and_stop();
    end
endmodule
